// ===== rtl/dac_update_pkg.sv
// Shared constants and types for the four-channel output update port
// Overview of operation
// - Controller writes low eight code bits in the same cycle as the upper bits
// - Controller writes upper four bits, shifted right
// - Codes are unsigned twelve bits, 0 to 4095
// - Only selected channels take the code
// - Several selects load the same code
// - Controller presents binary, converting BCD first
// - Sequencer visits channels one to four cyclically
// - Select read back gives one-scan pulse, advances
// - Sequencer starts first scan, parks in idle when enable drops
// - Upper image top nibble selects channels one-four
package dac_update_pkg;
   // -------------------------------------------------------------------
   // Widths and field positions
   // -------------------------------------------------------------------
   localparam int CODE_W       = 12;
   localparam int BYTE_W       = 8;
   localparam int NIBBLE_W     = 4;
   localparam int CHANNELS     = 4;
   localparam int SHIFT_PLACES = 8;
   localparam int SEL_LSB      = 4;
   localparam int BCD_DIGITS   = 3;
   localparam int BCD_RADIX    = 10;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
   localparam logic [CODE_W-1:0] CODE_MAX   = 12'hfff;
   localparam logic [CHANNELS-1:0] SEL_NONE = 4'h0;
   localparam logic [CHANNELS-1:0] SEL_FIRST = 4'h1;

   typedef enum {SEQ_IDLE, SEQ_DRIVE, SEQ_WAIT} seq_state_t;
endpackage

// ===== rtl/dac_update_if.sv
// Interface joining the controller end and the output module end
interface dac_update_if;
   logic [7:0] lowByteImage;            // Low code byte image
   logic [7:0] highNibbleSelectImage;   // Upper nibble and channel selects
   logic [3:0] selectReadBack;          // Selects read back as inputs

   modport controller (
      output lowByteImage,
      output highNibbleSelectImage,
      input  selectReadBack
   );
   modport module_end (
      input  lowByteImage,
      input  highNibbleSelectImage,
      output selectReadBack
   );
endinterface

// ===== rtl/dac_channel_bank.sv
// Output module end: four twelve-bit channel holding registers
module dac_channel_bank (
   input  wire logic              clk,        // 10 MHz clock
   input  wire logic              rst_b,      // Sync reset, active low
   input  wire logic              clkEn,      // Freezes state when low
   dac_update_if.module_end       bus,        // Controller side
   output logic [4*12-1:0]        chanCode    // Codes, channel 1 lowest
);
   localparam int CW = dac_update_pkg::CODE_W;
   localparam int NC = dac_update_pkg::CHANNELS;

   logic [CW-1:0]  code_q [NC];
   logic [CW-1:0]  code_d [NC];
   logic [CW-1:0]  presented;
   logic [NC-1:0]  select;
   logic [NC-1:0]  readBack_q;
   logic [NC-1:0]  readBack_d;

   // -------------------------------------------------------------------
   // Code assembly
   // -------------------------------------------------------------------
   // unsigned twelve-bit assembly
   assign presented = {bus.highNibbleSelectImage[dac_update_pkg::NIBBLE_W-1:0],
                       bus.lowByteImage};
   assign select = bus.highNibbleSelectImage[dac_update_pkg::SEL_LSB +: NC];

   always_comb begin
      for (int i = 0; i < NC; i++) begin
         code_d[i] = select[i] ? presented : code_q[i];
      end
      readBack_d = select;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < NC; i++) begin
            code_q[i] <= dac_update_pkg::CODE_RESET;
         end
         readBack_q <= dac_update_pkg::SEL_NONE;
      end else if (clkEn) begin
         code_q     <= code_d;
         readBack_q <= readBack_d;
      end
   end

   assign bus.selectReadBack = readBack_q;

   always_comb begin
      for (int i = 0; i < NC; i++) begin
         chanCode[i*CW +: CW] = code_q[i];
      end
   end
endmodule

// ===== rtl/dac_update_sequencer.sv
// Controller end: scan sequencer writing codes to the output module
module dac_update_sequencer #(
   parameter bit BCD_INPUT = 1'b0           // Sources are BCD when set
) (
   input  wire logic              clk,      // 10 MHz clock, one scan/cycle
   input  wire logic              rst_b,    // Sync reset, active low
   input  wire logic              clkEn,    // Freezes state when low
   input  wire logic              enable,   // Keep high every scan
   input  wire logic [4*12-1:0]   srcCode,  // Source values, ch1 lowest
   output logic [3:0]             curChan,  // One-hot channel in flight
   dac_update_if.controller       bus       // Module side
);
   localparam int CW = dac_update_pkg::CODE_W;
   localparam int NC = dac_update_pkg::CHANNELS;
   localparam int BW = dac_update_pkg::BYTE_W;
   localparam int NW = dac_update_pkg::NIBBLE_W;
   localparam int ND = dac_update_pkg::BCD_DIGITS;
   localparam int SP = dac_update_pkg::SHIFT_PLACES;
   localparam int IW = NC + NW;

   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   // The image layout and the rotate below assume exactly this shape
   if (NC != 4 || CW != 12) begin : g_chk
      $error("dac_update_sequencer serves four 12-bit channels only");
   end
   if (BW + NW != CW) begin : g_chk_split
      $error("low byte and upper nibble must make up one code");
   end
   if (SP != BW) begin : g_chk_shift
      $error("shift must drop exactly the low byte");
   end
   if (ND * NW != CW) begin : g_chk_bcd
      $error("BCD digits must fill the code width");
   end
   if (IW != 8) begin : g_chk_image
      $error("upper image must be eight points wide");
   end

   // -------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------
   dac_update_pkg::seq_state_t state_q;       // Scan step
   dac_update_pkg::seq_state_t state_d;
   logic [NC-1:0]              chan_q;        // One-hot channel in flight
   logic [NC-1:0]              chan_d;
   logic [BW-1:0]              low_q;         // Low byte image
   logic [BW-1:0]              low_d;
   logic [IW-1:0]              high_q;        // Selects and upper nibble
   logic [IW-1:0]              high_d;
   logic [CW-1:0]              srcWord [NC];  // Sources split per channel
   logic [CW-1:0]              raw;           // Source of current channel
   logic [CW-1:0]              digitVal [ND]; // Weighted BCD digits
   logic [CW-1:0]              bcd_to_binary_instr;           // BCD source as binary
   logic [CW-1:0]              acc;           // Code to present
   logic                       driveNow;      // Images load this scan
   logic                       readBackHit;   // Current channel echoed
   logic                       advance;       // Move to next channel

   // -------------------------------------------------------------------
   // Source pick
   // -------------------------------------------------------------------
   // Split the packed source bus into one word per channel
   for (genvar i = 0; i < NC; i++) begin : g_src
      assign srcWord[i] = srcCode[i*CW +: CW];
   end

   // Only the channel in flight feeds the accumulator
   always_comb begin
      raw = '0;
      for (int i = 0; i < NC; i++) begin
         if (chan_q[i]) begin
            raw = srcWord[i];
         end
      end
   end

   // -------------------------------------------------------------------
   // BCD conversion
   // -------------------------------------------------------------------
   // BCD to binary
   // Each decimal digit is scaled by its power of ten; digits above
   // nine are not trapped and simply scale as they stand
   for (genvar d = 0; d < ND; d++) begin : g_bcd
      localparam logic [CW-1:0] WEIGHT =
         CW'(dac_update_pkg::BCD_RADIX ** d);
      assign digitVal[d] = CW'(CW'(raw[d*NW +: NW]) * WEIGHT);
   end

   always_comb begin
      bcd_to_binary_instr = '0;
      for (int d = 0; d < ND; d++) begin
         bcd_to_binary_instr = CW'(bcd_to_binary_instr + digitVal[d]);
      end
   end

   // keep code in range
   // The mask keeps an oversized BCD result from spilling into selects
   assign acc = (BCD_INPUT ? bcd_to_binary_instr : raw) & dac_update_pkg::CODE_MAX;

   // -------------------------------------------------------------------
   // Handshake decode
   // -------------------------------------------------------------------
   assign driveNow = (state_q == dac_update_pkg::SEQ_DRIVE);

   // readback advances one step
   // Only the echo of the channel in flight counts, so a stale echo of
   // the previous channel cannot skip one
   assign readBackHit = |(bus.selectReadBack & chan_q);
   assign advance     = (state_q == dac_update_pkg::SEQ_WAIT)
                        && readBackHit;

   // -------------------------------------------------------------------
   // Scan state
   // -------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         dac_update_pkg::SEQ_IDLE: begin
            if (enable) begin
               state_d = dac_update_pkg::SEQ_DRIVE;
            end
         end
         dac_update_pkg::SEQ_DRIVE: begin
            state_d = dac_update_pkg::SEQ_WAIT;
         end
         dac_update_pkg::SEQ_WAIT: begin
            // Parks in idle after this channel if enable has dropped
            if (advance) begin
               state_d = enable ? dac_update_pkg::SEQ_DRIVE
                                : dac_update_pkg::SEQ_IDLE;
            end
         end
         default: begin
            state_d = dac_update_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= dac_update_pkg::SEQ_IDLE;
      end else if (clkEn) begin
         state_q <= state_d;
      end
   end

   // -------------------------------------------------------------------
   // Channel pointer
   // -------------------------------------------------------------------
   always_comb begin
      chan_d = chan_q;
      case (state_q)
         dac_update_pkg::SEQ_IDLE,
         dac_update_pkg::SEQ_DRIVE: begin
            chan_d = chan_q;
         end
         dac_update_pkg::SEQ_WAIT: begin
            if (advance) begin
               chan_d = {chan_q[NC-2:0], chan_q[NC-1]};
            end
         end
         default: begin
            chan_d = dac_update_pkg::SEL_FIRST;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chan_q <= dac_update_pkg::SEL_FIRST;
      end else if (clkEn) begin
         chan_q <= chan_d;
      end
   end

   // -------------------------------------------------------------------
   // Register images
   // -------------------------------------------------------------------
   always_comb begin
      low_d  = low_q;
      // Selects fall after one scan, giving the update pulse
      high_d = {dac_update_pkg::SEL_NONE, high_q[NW-1:0]};
      if (driveNow) begin
         low_d  = acc[BW-1:0];
         high_d = {chan_q, NW'(acc >> SP)};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         low_q  <= '0;
         high_q <= '0;
      end else if (clkEn) begin
         low_q  <= low_d;
         high_q <= high_d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign bus.lowByteImage          = low_q;
   assign bus.highNibbleSelectImage = high_q;
   assign curChan                   = chan_q;
endmodule

// ===== testbench/dac_update_assertions.sv
// Checker for the update port interface
module dac_update_assertions (
   input wire logic       clk,                   // Clock
   input wire logic       rst_b,                 // Sync reset, active low
   input wire logic [7:0] lowByteImage,          // Low code byte
   input wire logic [7:0] highNibbleSelectImage, // Nibble and selects
   input wire logic [3:0] selectReadBack         // Selects read back
);
   // ----------------
   // Port checks
   // ----------------
   wire logic [3:0] sel = highNibbleSelectImage[7:4];
   wire logic [3:0] rot = {selectReadBack[2:0], selectReadBack[3]};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_gap; !(|sel) [*2]; endsequence
   property p_echo; |sel |=> selectReadBack == $past(sel); endproperty
   a_echo: assert property (p_echo) else $error("bad readback");
   property p_back; |selectReadBack |-> $past(sel) == selectReadBack;
   endproperty
   a_back: assert property (p_back) else $error("stray readback");
   property p_pulse; |sel |=> s_gap; endproperty
   a_pulse: assert property (p_pulse) else $error("long select");
   property p_onehot; $onehot0(sel); endproperty
   a_onehot: assert property (p_onehot) else $error("two selects");
   property p_quiet; !(|sel) |=> selectReadBack == 4'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("readback on");
   property p_order; |selectReadBack |-> ##2 sel == $past(rot, 2);
   endproperty
   a_order: assert property (p_order) else $error("bad order");
   property p_first; $rose(rst_b) |-> ##[1:4] sel == 4'h1; endproperty
   a_first: assert property (p_first) else $error("no start");
   property p_period; |sel |-> ##3 |sel; endproperty
   a_period: assert property (p_period) else $error("stalled");
endmodule

// ===== testbench/four_channel_dac_update_port_tb.sv
// Testbench for the four-channel output update port
module four_channel_dac_update_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk;
   logic         rst_b;
   logic         clkEnB;
   logic [47:0]  srcCode;
   logic [47:0]  srcBcd;
   logic [47:0]  chanCode;
   logic [47:0]  chanCodeB;
   logic [47:0]  chanCodeC;
   logic [3:0]   curChan;
   int           error_cnt;
   int           check_count;
   dac_update_if busA ();
   dac_update_if busB ();
   dac_update_if busC ();
   dac_update_sequencer i_dac_update_sequencer (.clk(clk), .rst_b(rst_b),
      .clkEn(1'b1), .enable(1'b1), .srcCode(srcCode), .curChan(curChan),
      .bus(busA));
   dac_update_sequencer #(.BCD_INPUT(1'b1)) i_dac_update_sequencer_c (
      .clk(clk), .rst_b(rst_b), .clkEn(1'b1), .enable(1'b1),
      .srcCode(srcBcd), .curChan(), .bus(busC));
   dac_channel_bank i_dac_channel_bank (.clk(clk), .rst_b(rst_b),
      .clkEn(1'b1), .bus(busA), .chanCode(chanCode));
   dac_channel_bank i_dac_channel_bank_b (.clk(clk), .rst_b(rst_b),
      .clkEn(clkEnB), .bus(busB), .chanCode(chanCodeB));
   dac_channel_bank i_dac_channel_bank_c (.clk(clk), .rst_b(rst_b),
      .clkEn(1'b1), .bus(busC), .chanCode(chanCodeC));
   dac_update_assertions i_dac_update_assertions (.clk(clk),
      .rst_b(rst_b), .lowByteImage(busA.lowByteImage),
      .highNibbleSelectImage(busA.highNibbleSelectImage),
      .selectReadBack(busA.selectReadBack));
   task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic chk_all(logic [47:0] got, logic [47:0] exp);
      for (int i = 0; i < 4; i++) begin
         check("chanCode", got[i*12+:12], exp[i*12+:12]);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_rb(int ch);
      int n;
      n = 0;
      @(negedge clk);
      while (busA.selectReadBack[ch] !== 1'b1 && n <= 40) begin
         n++;
         @(negedge clk);
      end
      if (n > 40) begin
         error_cnt++;
         $display("[FAIL] readBack wait expected 1 seen 0");
      end
   endtask
   // Drives one update into the second bank by hand
   task automatic put(logic [11:0] code, logic [3:0] sel);
      @(posedge clk);
      busB.lowByteImage <= code[7:0];
      busB.highNibbleSelectImage <= {sel, code[11:8]};
      @(posedge clk);
      busB.highNibbleSelectImage <= {4'h0, code[11:8]};
      @(negedge clk);
      check("readBack", {8'h00, busB.selectReadBack}, {8'h00, sel});
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst_b = 1'b0;
      srcCode = {12'hfff, 12'h000, 12'h5a3, 12'h801};
      srcBcd = {12'h999, 12'h000, 12'h123, 12'h409};
      clkEnB = 1'b1;
      busB.lowByteImage = 8'h00;
      busB.highNibbleSelectImage = 8'h00;
      error_cnt = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wait_rb(3);
      chk_all(chanCode, srcCode);
      chk_all(chanCodeC, {12'h3e7, 12'h000, 12'h07b, 12'h199});
      check("curChan", {8'h00, curChan}, 12'h008);
      @(posedge clk);
      srcCode[23:12] <= 12'h3c7;
      wait_rb(1);
      chk_all(chanCode, {12'hfff, 12'h000, 12'h3c7, 12'h801});
      put(12'habc, 4'h5);
      chk_all(chanCodeB, {12'h000, 12'habc, 12'h000, 12'habc});
      put(12'h123, 4'h2);
      chk_all(chanCodeB, {12'h000, 12'habc, 12'h123, 12'habc});
      @(posedge clk);
      clkEnB <= 1'b0;
      busB.lowByteImage <= 8'h77;
      busB.highNibbleSelectImage <= 8'hf7;
      @(posedge clk);
      busB.highNibbleSelectImage <= 8'h07;
      @(posedge clk);
      clkEnB <= 1'b1;
      @(negedge clk);
      check("readBack", {8'h00, busB.selectReadBack}, 12'h000);
      chk_all(chanCodeB, {12'h000, 12'habc, 12'h123, 12'habc});
      end_sim();
   end
endmodule
